/* rtl/mcbr_bank.sv */
`timescale 1ns/10ps
`default_nettype none
`include "mcbr_map.svh"
module mcbr_bank (
    input wire logic clk_in,
    input wire logic nrst_in,
    mcbr_if.bankm rb
);
    logic [7:0] ram_r [0:31];
    logic [7:0] rd_r, rd_nxt;
    logic [4:0] addr;

    // Bank bits form the upper part of the low RAM address
    always_comb begin
        addr = {rb.bank, rb.idx};
        rd_nxt = rb.rg_wr ? rb.rg_wdata : ram_r[addr];
    end

    // Storage has no reset, only the read register does
    always_ff @(posedge clk_in) begin
        if (rb.rg_wr) begin
            ram_r[addr] <= rb.rg_wdata;
        end
        if (!nrst_in) begin
            rd_r <= `MCBR_RST_BYTE;
        end else begin
            rd_r <= rd_nxt;
        end
    end

    assign rb.rg_rdata = rd_r;
endmodule
`default_nettype wire

/* rtl/mcbr_data_pointer_word.sv */
`timescale 1ns/10ps
`default_nettype none
`include "mcbr_map.svh"
module mcbr_data_pointer_word (
    input wire logic clk_in,
    input wire logic nrst_in,
    mcbr_if.data_pointer_word dp
);
    logic [15:0] main_r, main_nxt;
    logic [15:0] shad_r, shad_nxt;
    logic [15:0] act;

    // Only the active pointer moves; the other keeps its value
    always_comb begin
        main_nxt = main_r;
        shad_nxt = shad_r;
        act = dp.dp_shadow ? shad_r : main_r;
        if (dp.dp_wr_word) begin
            act = dp.dp_wdata;
        end else begin
            if (dp.dp_wr_lo) begin
                act[7:0] = dp.dp_wdata[7:0];
            end
            if (dp.dp_wr_hi) begin
                act[15:8] = dp.dp_wdata[15:8];
            end
        end
        if (dp.dp_shadow) begin
            shad_nxt = act;
        end else begin
            main_nxt = act;
        end
    end

    // Read port shows the pointer selected this cycle
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            main_r <= `MCBR_RST_WORD;
            shad_r <= `MCBR_RST_WORD;
        end else begin
            main_r <= main_nxt;
            shad_r <= shad_nxt;
        end
    end

    assign dp.dp_rdata = dp.dp_shadow ? shad_r : main_r;
endmodule
`default_nettype wire

/* rtl/mcbr_top.sv */
// Functional notes
// - Upper pointer byte, eight bits, reset zero
// - Pointer word is upper and lower bytes
// - Stack pointer byte resets to seven
// - Bit six selects enhanced UART checking
// - Bit five hands shared pins I2C/SPI
// - Bit four enables 38 kHz pin modulation
// - Either low bit enables extended RAM moves
// - Counter resets zero, advances by length
// - Counter not register mapped; jumps load it
// - Opcode held internally, not software visible
// - Four banks in first 32 RAM bytes
// - Register operand one cycle, else two
// - Parity flag always tracks accumulator
// - B feeds multiply and divide operand
// - Status word bits are bit addressable
// - Accesses act on the active pointer
// - Arithmetic results update overflow flag
// - Push pre-increments, pop post-decrements
`timescale 1ns/10ps
`default_nettype none
`include "mcbr_map.svh"
module mcbr_top (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic [7:0] sfr_wdata_in,
    output logic [7:0] sfr_rdata_out,
    input wire logic [7:0] bit_addr_in,
    input wire logic bit_wr_in,
    input wire logic bit_wdata_in,
    output logic bit_rdata_out,
    input wire logic ir_load_in,
    input wire logic [7:0] opcode_in,
    input wire logic [1:0] op_src_in,
    input wire logic instr_done_in,
    input wire logic [1:0] instr_len_in,
    input wire logic jump_in,
    input wire logic [15:0] jump_addr_in,
    input wire logic acc_wr_in,
    input wire logic [7:0] acc_wdata_in,
    input wire logic b_wr_in,
    input wire logic [7:0] b_wdata_in,
    input wire logic flags_wr_in,
    input wire logic cy_in,
    input wire logic ac_in,
    input wire logic ov_in,
    input wire logic push_in,
    input wire logic pop_in,
    input wire logic dp_shadow_in,
    input wire logic dp_word_wr_in,
    input wire logic [15:0] dp_word_in,
    input wire logic [2:0] wreg_idx_in,
    input wire logic wreg_wr_in,
    input wire logic [7:0] wreg_wdata_in,
    output logic [7:0] wreg_rdata_out,
    output logic [15:0] program_counter_out,
    output logic [7:0] opcode_out,
    output logic [1:0] exec_cycles_out,
    output logic [7:0] acc_out,
    output logic [7:0] b_operand_out,
    output logic [7:0] program_status_word_out,
    output logic [7:0] stack_address_low_out,
    output logic [15:0] data_pointer_word_out,
    output logic uart_enhanced_enable_out,
    output logic serial_port_select_out,
    output logic xram_enable_out,
    output logic [7:0] modulated_pins_out
);
    mcbr_if link ();

    logic [7:0] acc_r, acc_nxt;
    logic [7:0] b_r, b_nxt;
    logic [7:0] psw_r, psw_nxt;
    logic [7:0] sp_r, sp_nxt;
    logic [7:0] cfg_r, cfg_nxt;
    logic [7:0] extended_port_configuration_r, extended_port_configuration_nxt;
    logic [15:0] pc_r, pc_nxt;
    logic [7:0] ir_r, ir_nxt;
    logic [1:0] cyc_r, cyc_nxt;
    logic [`MCBR_MOD_CW-1:0] div_r, div_nxt;
    logic car_r, car_nxt;
    logic [7:0] mod_r, mod_nxt;
    logic [7:0] rd_r, rd_nxt;
    logic bit_r, bit_nxt;
    logic [7:0] bit_byte;
    logic [7:0] bit_new;
    mcbr_pkg::mcbr_sel_t wsel, bsel;
    logic w_is_b, bb_is_b;

    // Shared decode for byte and bit paths; B handled on the side
    function automatic mcbr_pkg::mcbr_sel_t dec(input logic [7:0] a);
        if (a == `MCBR_A_SP) begin
            dec = mcbr_pkg::MCBR_T_SP;
        end else if (a == `MCBR_A_DPL) begin
            dec = mcbr_pkg::MCBR_T_DPL;
        end else if (a == `MCBR_A_DPH) begin
            dec = mcbr_pkg::MCBR_T_DPH;
        end else if (a == `MCBR_A_EXTENDED_PORT_CONFIGURATION) begin
            dec = mcbr_pkg::MCBR_T_EXTENDED_PORT_CONFIGURATION;
        end else if (a == `MCBR_A_CFG) begin
            dec = mcbr_pkg::MCBR_T_CFG;
        end else if (a == `MCBR_A_PSW) begin
            dec = mcbr_pkg::MCBR_T_PSW;
        end else if (a == `MCBR_A_ACC) begin
            dec = mcbr_pkg::MCBR_T_ACC;
        end else begin
            dec = mcbr_pkg::MCBR_T_NONE;
        end
    endfunction

    // Only ACC, B and the status word answer bit addresses
    function automatic logic bit_ok(input logic [7:0] a);
        bit_ok = a[7] && ((a[7:3] == `MCBR_A_PSW >> 3)
            || (a[7:3] == `MCBR_A_ACC >> 3)
            || (a[7:3] == `MCBR_A_B >> 3));
    endfunction

    // Address decode for both access paths
    always_comb begin
        wsel = dec(sfr_addr_in);
        w_is_b = (sfr_addr_in == `MCBR_A_B);
        bsel = dec({bit_addr_in[7:3], 3'b000});
        bb_is_b = ({bit_addr_in[7:3], 3'b000} == `MCBR_A_B);
        if (!bit_ok(bit_addr_in)) begin
            bsel = mcbr_pkg::MCBR_T_NONE;
        end
        if (bb_is_b) begin
            bit_byte = b_r;
        end else if (bsel == mcbr_pkg::MCBR_T_PSW) begin
            bit_byte = psw_r;
        end else if (bsel == mcbr_pkg::MCBR_T_ACC) begin
            bit_byte = acc_r;
        end else begin
            bit_byte = 8'h00;
        end
        bit_new = bit_byte;
        bit_new[bit_addr_in[2:0]] = bit_wdata_in;
    end

    // Architectural registers; software writes win over datapath
    always_comb begin
        acc_nxt = acc_r;
        b_nxt = b_r;
        psw_nxt = psw_r;
        sp_nxt = sp_r;
        cfg_nxt = cfg_r;
        extended_port_configuration_nxt = extended_port_configuration_r;
        if (acc_wr_in) begin
            acc_nxt = acc_wdata_in;
        end
        if (b_wr_in) begin
            b_nxt = b_wdata_in;
        end
        if (flags_wr_in) begin
            psw_nxt[`MCBR_PSW_CY] = cy_in;
            psw_nxt[`MCBR_PSW_AC] = ac_in;
            psw_nxt[`MCBR_PSW_OV] = ov_in;
        end
        if (push_in && !pop_in) begin
            sp_nxt = sp_r + 8'h01;
        end else if (pop_in && !push_in) begin
            sp_nxt = sp_r - 8'h01;
        end
        if (sfr_wr_in) begin
            if (w_is_b) begin
                b_nxt = sfr_wdata_in;
            end else if (wsel == mcbr_pkg::MCBR_T_ACC) begin
                acc_nxt = sfr_wdata_in;
            end else if (wsel == mcbr_pkg::MCBR_T_PSW) begin
                psw_nxt = sfr_wdata_in;
            end else if (wsel == mcbr_pkg::MCBR_T_SP) begin
                sp_nxt = sfr_wdata_in;
            end else if (wsel == mcbr_pkg::MCBR_T_CFG) begin
                cfg_nxt = sfr_wdata_in & `MCBR_CFG_WMASK;
            end else if (wsel == mcbr_pkg::MCBR_T_EXTENDED_PORT_CONFIGURATION) begin
                extended_port_configuration_nxt = sfr_wdata_in;
            end
        end
        if (bit_wr_in) begin
            if (bb_is_b) begin
                b_nxt = bit_new;
            end else if (bsel == mcbr_pkg::MCBR_T_PSW) begin
                psw_nxt = bit_new;
            end else if (bsel == mcbr_pkg::MCBR_T_ACC) begin
                acc_nxt = bit_new;
            end
        end
        // Parity is derived, so a written value never sticks
        psw_nxt[`MCBR_PSW_P] = ^acc_nxt;
    end
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            acc_r <= `MCBR_RST_BYTE;
            b_r <= `MCBR_RST_BYTE;
            psw_r <= `MCBR_RST_BYTE;
            sp_r <= `MCBR_RST_SP;
            cfg_r <= `MCBR_RST_CFG;
            extended_port_configuration_r <= `MCBR_RST_BYTE;
        end else begin
            acc_r <= acc_nxt;
            b_r <= b_nxt;
            psw_r <= psw_nxt;
            sp_r <= sp_nxt;
            cfg_r <= cfg_nxt;
            extended_port_configuration_r <= extended_port_configuration_nxt;
        end
    end

    // Counter and opcode live outside the register map
    always_comb begin
        pc_nxt = pc_r;
        ir_nxt = ir_r;
        cyc_nxt = cyc_r;
        if (jump_in) begin
            pc_nxt = jump_addr_in;
        end else if (instr_done_in) begin
            pc_nxt = pc_r + {14'h0000, instr_len_in};
        end
        if (ir_load_in) begin
            ir_nxt = opcode_in;
            if (op_src_in == mcbr_pkg::MCBR_SRC_REG) begin
                cyc_nxt = 2'h1;
            end else begin
                cyc_nxt = 2'h2;
            end
        end
    end
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            pc_r <= `MCBR_RST_PC;
            ir_r <= `MCBR_RST_BYTE;
            cyc_r <= 2'h1;
        end else begin
            pc_r <= pc_nxt;
            ir_r <= ir_nxt;
            cyc_r <= cyc_nxt;
        end
    end

    // Carrier divider; half period rounds down so rate sits just above
    always_comb begin
        div_nxt = div_r + `MCBR_MOD_CW'(1);
        car_nxt = car_r;
        if (div_r == `MCBR_MOD_CW'(`MCBR_MOD_HALF - 1)) begin
            div_nxt = '0;
            car_nxt = !car_r;
        end
        mod_nxt = 8'h00;
        if (cfg_r[`MCBR_CFG_MOD]) begin
            mod_nxt = extended_port_configuration_r & {8{car_r}};
        end
    end
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            div_r <= '0;
            car_r <= 1'b0;
            mod_r <= 8'h00;
        end else begin
            div_r <= div_nxt;
            car_r <= car_nxt;
            mod_r <= mod_nxt;
        end
    end

    // Read data is registered, so it appears the cycle after the address
    always_comb begin
        rd_nxt = 8'h00;
        if (w_is_b) begin
            rd_nxt = b_r;
        end else if (wsel == mcbr_pkg::MCBR_T_ACC) begin
            rd_nxt = acc_r;
        end else if (wsel == mcbr_pkg::MCBR_T_PSW) begin
            rd_nxt = psw_r;
        end else if (wsel == mcbr_pkg::MCBR_T_SP) begin
            rd_nxt = sp_r;
        end else if (wsel == mcbr_pkg::MCBR_T_DPL) begin
            rd_nxt = link.dp_rdata[7:0];
        end else if (wsel == mcbr_pkg::MCBR_T_DPH) begin
            rd_nxt = link.dp_rdata[15:8];
        end else if (wsel == mcbr_pkg::MCBR_T_CFG) begin
            rd_nxt = cfg_r & `MCBR_CFG_WMASK;
        end else if (wsel == mcbr_pkg::MCBR_T_EXTENDED_PORT_CONFIGURATION) begin
            rd_nxt = extended_port_configuration_r;
        end
        bit_nxt = bit_byte[bit_addr_in[2:0]];
    end
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            rd_r <= 8'h00;
            bit_r <= 1'b0;
        end else begin
            rd_r <= rd_nxt;
            bit_r <= bit_nxt;
        end
    end

    // Pointer and bank hookup
    assign link.dp_shadow = dp_shadow_in;
    assign link.dp_wr_word = dp_word_wr_in;
    assign link.dp_wr_lo = sfr_wr_in && (wsel == mcbr_pkg::MCBR_T_DPL);
    assign link.dp_wr_hi = sfr_wr_in && (wsel == mcbr_pkg::MCBR_T_DPH);
    assign link.dp_wdata = dp_word_wr_in ? dp_word_in
        : {sfr_wdata_in, sfr_wdata_in};
    assign link.bank = psw_r[`MCBR_PSW_RS1:`MCBR_PSW_RS0];
    assign link.idx = wreg_idx_in;
    assign link.rg_wr = wreg_wr_in;
    assign link.rg_wdata = wreg_wdata_in;

    mcbr_data_pointer_word u_data_pointer_word (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .dp(link.data_pointer_word)
    );
    mcbr_bank u_bank (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .rb(link.bankm)
    );

    // Outputs from flip-flops, but the pointer word passes the shadow mux and xram enable an OR
    assign sfr_rdata_out = rd_r;
    assign bit_rdata_out = bit_r;
    assign wreg_rdata_out = link.rg_rdata;
    assign program_counter_out = pc_r;
    assign opcode_out = ir_r;
    assign exec_cycles_out = cyc_r;
    assign acc_out = acc_r;
    assign b_operand_out = b_r;
    assign program_status_word_out = psw_r;
    assign stack_address_low_out = sp_r;
    assign data_pointer_word_out = link.dp_rdata;
    assign uart_enhanced_enable_out = cfg_r[`MCBR_CFG_UART];
    assign serial_port_select_out = cfg_r[`MCBR_CFG_SPI];
    assign xram_enable_out = cfg_r[`MCBR_CFG_XR1]
        | cfg_r[`MCBR_CFG_XR0];
    assign modulated_pins_out = mod_r;
endmodule
`default_nettype wire

/* shared/mcbr_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface mcbr_if;
    logic dp_shadow;
    logic dp_wr_lo;
    logic dp_wr_hi;
    logic dp_wr_word;
    logic [15:0] dp_wdata;
    logic [15:0] dp_rdata;
    logic [1:0] bank;
    logic [2:0] idx;
    logic rg_wr;
    logic [7:0] rg_wdata;
    logic [7:0] rg_rdata;

    modport core (
        output dp_shadow, dp_wr_lo, dp_wr_hi, dp_wr_word, dp_wdata,
        input dp_rdata,
        output bank, idx, rg_wr, rg_wdata,
        input rg_rdata
    );
    modport data_pointer_word (
        input dp_shadow, dp_wr_lo, dp_wr_hi, dp_wr_word, dp_wdata,
        output dp_rdata
    );
    modport bankm (
        input bank, idx, rg_wr, rg_wdata,
        output rg_rdata
    );
endinterface
`default_nettype wire

/* shared/mcbr_map.svh */
`ifndef MCBR_MAP_SVH
`define MCBR_MAP_SVH

// Direct special function register addresses
`define MCBR_A_SP 8'h81
`define MCBR_A_DPL 8'h82
`define MCBR_A_DPH 8'h83
`define MCBR_A_EXTENDED_PORT_CONFIGURATION 8'h9F
`define MCBR_A_CFG 8'hAF
`define MCBR_A_PSW 8'hD0
`define MCBR_A_ACC 8'hE0
`define MCBR_A_B 8'hF0

// Reset values
`define MCBR_RST_SP 8'h07
`define MCBR_RST_BYTE 8'h00
`define MCBR_RST_WORD 16'h0000
`define MCBR_RST_CFG 8'h80
`define MCBR_RST_PC 16'h0000

// Configuration field positions
`define MCBR_CFG_KEEP 7
`define MCBR_CFG_UART 6
`define MCBR_CFG_SPI 5
`define MCBR_CFG_MOD 4
`define MCBR_CFG_XR1 1
`define MCBR_CFG_XR0 0
`define MCBR_CFG_WMASK 8'hF3

// Status word field positions
`define MCBR_PSW_CY 7
`define MCBR_PSW_AC 6
`define MCBR_PSW_F0 5
`define MCBR_PSW_RS1 4
`define MCBR_PSW_RS0 3
`define MCBR_PSW_OV 2
`define MCBR_PSW_F1 1
`define MCBR_PSW_P 0

// Carrier timing: core clock and modulation rate in Hz
`define MCBR_CLK_HZ 40000000
`define MCBR_MOD_HZ 38000
`define MCBR_MOD_HALF (`MCBR_CLK_HZ / (2 * `MCBR_MOD_HZ))
`define MCBR_MOD_CW 10

`endif

/* shared/mcbr_pkg.sv */
package mcbr_pkg;
    // Decoded target of a direct or bit address
    typedef enum logic [2:0] {
        MCBR_T_NONE,
        MCBR_T_SP,
        MCBR_T_DPL,
        MCBR_T_DPH,
        MCBR_T_EXTENDED_PORT_CONFIGURATION,
        MCBR_T_CFG,
        MCBR_T_PSW,
        MCBR_T_ACC
    } mcbr_sel_t;

    // B is kept apart to fit the three-bit code
    typedef enum logic [1:0] {
        MCBR_SRC_REG,
        MCBR_SRC_LIT,
        MCBR_SRC_RAM
    } mcbr_src_t;
endpackage

/* testbench/mcbr_top_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module mcbr_top_monitor (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic [7:0] sfr_rdata_out,
    input wire logic ir_load_in,
    input wire logic [1:0] op_src_in,
    input wire logic instr_done_in,
    input wire logic [1:0] instr_len_in,
    input wire logic jump_in,
    input wire logic [15:0] jump_addr_in,
    input wire logic push_in,
    input wire logic pop_in,
    input wire logic [15:0] program_counter_out,
    input wire logic [1:0] exec_cycles_out,
    input wire logic [7:0] acc_out,
    input wire logic [7:0] program_status_word_out,
    input wire logic [7:0] stack_address_low_out,
    input wire logic uart_enhanced_enable_out,
    input wire logic serial_port_select_out,
    input wire logic xram_enable_out,
    input wire logic [7:0] modulated_pins_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    logic sp_wr, cfg_wr;
    // Register writes to SP, which override the datapath, and to CFG
    assign sp_wr = sfr_wr_in && (sfr_addr_in == 8'h81);
    assign cfg_wr = sfr_wr_in && (sfr_addr_in == 8'hAF);
    // Stack and counter movement
    a_sp_push_inc: assert property (
        push_in && !pop_in && !sp_wr |=>
        stack_address_low_out == $past(stack_address_low_out) + 8'h01)
        else $error("stack pointer did not rise by one");
    a_sp_pop_dec: assert property (
        pop_in && !push_in && !sp_wr |=>
        stack_address_low_out == $past(stack_address_low_out) - 8'h01)
        else $error("stack pointer did not fall by one");
    a_pc_advance: assert property (
        instr_done_in && !jump_in |=> program_counter_out ==
        $past(program_counter_out) + 16'($past(instr_len_in)))
        else $error("program counter did not advance by length");
    a_pc_jump_load: assert property (
        jump_in |=> program_counter_out == $past(jump_addr_in))
        else $error("program counter missed jump target");
    // Parity is checked every cycle, not only after writes
    a_parity_track: assert property (
        program_status_word_out[0] == ^acc_out)
        else $error("parity flag out of step with accumulator");
    a_cfg_fields: assert property (
        cfg_wr |=> uart_enhanced_enable_out == $past(sfr_wdata_in[6]) &&
        serial_port_select_out == $past(sfr_wdata_in[5]) &&
        xram_enable_out == |$past(sfr_wdata_in[1:0]))
        else $error("configuration outputs do not follow write");
    a_mod_off: assert property (
        cfg_wr && !sfr_wdata_in[4] ##1 !cfg_wr |=>
        modulated_pins_out == 8'h00)
        else $error("pins modulated while disabled");
    a_exec_cycles: assert property (
        ir_load_in |=> exec_cycles_out ==
        (($past(op_src_in) == 2'h0) ? 2'h1 : 2'h2))
        else $error("cycle count wrong for operand source");
    a_cfg_reserved: assert property (
        cfg_wr ##1 (sfr_addr_in == 8'hAF && !sfr_wr_in) |=>
        sfr_rdata_out == ($past(sfr_wdata_in, 2) & 8'hF3))
        else $error("configuration read back wrong");
endmodule
bind mcbr_top mcbr_top_monitor u_mcbr_top_monitor (.clk_in, .nrst_in,
    .sfr_addr_in, .sfr_wr_in, .sfr_wdata_in, .sfr_rdata_out, .ir_load_in,
    .op_src_in, .instr_done_in, .instr_len_in, .jump_in, .jump_addr_in,
    .push_in, .pop_in, .program_counter_out, .exec_cycles_out, .acc_out,
    .program_status_word_out, .stack_address_low_out,
    .uart_enhanced_enable_out, .serial_port_select_out, .xram_enable_out,
    .modulated_pins_out);
`default_nettype wire

/* testbench/mcbr_top_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "mcbr_map.svh"
module mcbr_top_tb_top;
    logic clk_in, nrst_in, sfr_wr_in, bit_wr_in, bit_wdata_in, ir_load_in;
    logic instr_done_in, jump_in, acc_wr_in, b_wr_in, flags_wr_in, cy_in;
    logic ac_in, ov_in, push_in, pop_in, dp_shadow_in, dp_word_wr_in;
    logic wreg_wr_in, bit_rdata_out, uart_enhanced_enable_out;
    logic serial_port_select_out, xram_enable_out;
    logic [1:0] op_src_in, instr_len_in, exec_cycles_out;
    logic [2:0] wreg_idx_in;
    logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out, bit_addr_in;
    logic [7:0] opcode_in, acc_wdata_in, b_wdata_in, wreg_wdata_in;
    logic [7:0] wreg_rdata_out, opcode_out, acc_out, b_operand_out;
    logic [7:0] program_status_word_out, stack_address_low_out;
    logic [7:0] modulated_pins_out;
    logic [15:0] jump_addr_in, dp_word_in, program_counter_out;
    logic [15:0] data_pointer_word_out;
    int errors, compares, i, n;
    // Address, write data, expected read back
    logic [7:0] rows [10][3] = '{
        '{8'h81, 8'h30, 8'h30}, '{8'h82, 8'hA5, 8'hA5},
        '{8'h83, 8'h5A, 8'h5A}, '{8'hAF, 8'hFF, 8'hF3},
        '{8'hAF, 8'h80, 8'h80}, '{8'h9F, 8'h3C, 8'h3C},
        '{8'hD0, 8'h19, 8'h18}, '{8'hE0, 8'h07, 8'h07},
        '{8'hF0, 8'hC3, 8'hC3}, '{8'h84, 8'hFF, 8'h00}
    };

    mcbr_top u_mcbr_top (
        .clk_in, .nrst_in, .sfr_addr_in, .sfr_wr_in, .sfr_wdata_in,
        .sfr_rdata_out, .bit_addr_in, .bit_wr_in, .bit_wdata_in,
        .bit_rdata_out, .ir_load_in, .opcode_in, .op_src_in, .instr_done_in,
        .instr_len_in, .jump_in, .jump_addr_in, .acc_wr_in, .acc_wdata_in,
        .b_wr_in, .b_wdata_in, .flags_wr_in, .cy_in, .ac_in, .ov_in,
        .push_in, .pop_in, .dp_shadow_in, .dp_word_wr_in, .dp_word_in,
        .wreg_idx_in, .wreg_wr_in, .wreg_wdata_in, .wreg_rdata_out,
        .program_counter_out, .opcode_out, .exec_cycles_out, .acc_out,
        .b_operand_out, .program_status_word_out, .stack_address_low_out,
        .data_pointer_word_out, .uart_enhanced_enable_out,
        .serial_port_select_out, .xram_enable_out, .modulated_pins_out
    );

    // 40 MHz core clock
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    // Compare and count; four-state so an unknown never matches a known value
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %0h expected %0h", $time,
                seen, exp);
        end
    endtask

    task automatic final_report();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Bus tasks start and end on a falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr_in = a;
        sfr_wdata_in = d;
        sfr_wr_in = 1'b1;
        @(negedge clk_in);
        sfr_wr_in = 1'b0;
        // Idle cycle so a following write never re-raises the strobe at once
        @(negedge clk_in);
    endtask

    task automatic rd(input logic [7:0] a);
        sfr_addr_in = a;
        @(negedge clk_in);
    endtask

    task automatic do_reset();
        nrst_in = 1'b0;
        // Count rising edges so the first clock setup cannot steal a cycle
        repeat (6) @(posedge clk_in);
        @(negedge clk_in);
        nrst_in = 1'b1;
    endtask

    // Bounded wait on the pins; a stall ends the run as a failure
    task automatic wait_pins(input logic [7:0] v);
        n = 0;
        while (modulated_pins_out !== v && n < 1200) begin
            @(negedge clk_in);
            n++;
        end
        if (n < 1200) begin
            check(modulated_pins_out, v);
        end else begin
            errors++;
            final_report();
        end
    endtask

    // Main sequence
    initial begin
        errors = 0;
        compares = 0;
        {sfr_wr_in, bit_wr_in, bit_wdata_in, ir_load_in, instr_done_in,
            jump_in, acc_wr_in, b_wr_in, flags_wr_in, cy_in, ac_in, ov_in,
            push_in, pop_in, dp_shadow_in, dp_word_wr_in, wreg_wr_in} = '0;
        {op_src_in, instr_len_in, wreg_idx_in, sfr_addr_in, sfr_wdata_in,
            bit_addr_in, opcode_in, acc_wdata_in, b_wdata_in, wreg_wdata_in,
            jump_addr_in, dp_word_in} = '0;
        do_reset();
        for (i = 0; i < 10; i++) begin
            wr(rows[i][0], rows[i][1]);
            rd(rows[i][0]);
            check(sfr_rdata_out, rows[i][2]);
        end
        check(data_pointer_word_out, 16'h5AA5);
        $display("test register table done");
        // UART, serial select and extended RAM fields each steer their own output
        wr(8'hAF, 8'hE1);
        check({uart_enhanced_enable_out, serial_port_select_out,
            xram_enable_out}, 3'h7);
        wr(8'hAF, 8'h82);
        check({uart_enhanced_enable_out, serial_port_select_out,
            xram_enable_out}, 3'h1);
        wr(8'hAF, 8'h80);
        check(xram_enable_out, 1'b0);
        $display("test configuration done");
        // Two pushes, a cancelling pair, then a pop
        push_in = 1'b1;
        repeat (2) @(negedge clk_in);
        pop_in = 1'b1;
        @(negedge clk_in);
        push_in = 1'b0;
        @(negedge clk_in);
        pop_in = 1'b0;
        check(stack_address_low_out, 8'h31);
        // Lengths one to three back to back, then jump beats done
        instr_done_in = 1'b1;
        for (i = 1; i < 4; i++) begin
            instr_len_in = i[1:0];
            @(negedge clk_in);
        end
        check(program_counter_out, 16'h0006);
        jump_addr_in = 16'h1234;
        jump_in = 1'b1;
        @(negedge clk_in);
        instr_done_in = 1'b0;
        jump_in = 1'b0;
        check(program_counter_out, 16'h1234);
        // Every operand source loaded on consecutive cycles
        ir_load_in = 1'b1;
        for (i = 0; i < 3; i++) begin
            opcode_in = 8'hA0 + 8'(i);
            op_src_in = i[1:0];
            @(negedge clk_in);
            check(opcode_out, 8'hA0 + 8'(i));
            check(exec_cycles_out, (i == 0) ? 2'h1 : 2'h2);
        end
        ir_load_in = 1'b0;
        $display("test datapath counters done");
        // Same index in two banks holds two values
        wreg_idx_in = 3'h2;
        wreg_wdata_in = 8'h11;
        wreg_wr_in = 1'b1;
        @(negedge clk_in);
        wreg_wr_in = 1'b0;
        bit_addr_in = 8'hD4;
        bit_wr_in = 1'b1;
        @(negedge clk_in);
        bit_wr_in = 1'b0;
        wreg_wdata_in = 8'h22;
        wreg_wr_in = 1'b1;
        @(negedge clk_in);
        wreg_wr_in = 1'b0;
        @(negedge clk_in);
        check(wreg_rdata_out, 8'h22);
        check(bit_rdata_out, 1'b0);
        bit_wdata_in = 1'b1;
        bit_wr_in = 1'b1;
        @(negedge clk_in);
        bit_wr_in = 1'b0;
        @(negedge clk_in);
        check(wreg_rdata_out, 8'h11);
        check(program_status_word_out[4:3], 2'h3);
        // Shadow pointer write leaves the main pointer alone
        dp_shadow_in = 1'b1;
        dp_word_in = 16'hBEEF;
        dp_word_wr_in = 1'b1;
        @(negedge clk_in);
        dp_word_wr_in = 1'b0;
        check(data_pointer_word_out, 16'hBEEF);
        dp_shadow_in = 1'b0;
        @(negedge clk_in);
        check(data_pointer_word_out, 16'h5AA5);
        // Flags, accumulator and B loaded together
        {flags_wr_in, cy_in, ov_in, acc_wr_in, b_wr_in} = 5'h1F;
        acc_wdata_in = 8'h01;
        b_wdata_in = 8'h5C;
        @(negedge clk_in);
        {flags_wr_in, acc_wr_in, b_wr_in} = 3'h0;
        check(program_status_word_out, 8'h9D);
        check(b_operand_out, 8'h5C);
        check(acc_out, 8'h01);
        $display("test banks and pointers done");
        // Carrier half period measured on a full high phase
        wr(8'hAF, 8'h90);
        wait_pins(8'h3C);
        wait_pins(8'h00);
        wait_pins(8'h3C);
        wait_pins(8'h00);
        check(n[15:0], 16'(`MCBR_MOD_HALF));
        wait_pins(8'h3C);
        wr(8'hAF, 8'h80);
        @(negedge clk_in);
        check(modulated_pins_out, 8'h00);
        $display("test modulation done");
        // Second reset in mid-run restores every value except bank storage
        do_reset();
        rd(8'h81);
        check(sfr_rdata_out, 8'h07);
        rd(8'h83);
        check(sfr_rdata_out, 8'h00);
        check(data_pointer_word_out, 16'h0000);
        check(program_counter_out, 16'h0000);
        $display("test reset done");
        final_report();
    end
endmodule
`default_nettype wire
